//--- prio_int_pkg.sv
// Purpose: Shared constants and types of the priority interrupt controller
// Assumes: 16-bit register data, 8-bit word-index register addresses
// Notes: Register addresses are word indices on the plain register port
`default_nettype none
package prio_int_pkg;
  // ************
  // Sizes
  // ************
  localparam int NSRC = 30;
  localparam int NCH = 8;
  localparam int NEXT = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int EXT_SRC_BASE = 8;
  // ************
  // Register map
  // ************
  localparam logic [7:0] A_SRC_BASE = 8'h00;
  localparam logic [7:0] A_SRC_END = 8'h1e;
  localparam logic [7:0] A_CH_BASE = 8'h20;
  localparam logic [1:0] CH_SRC = 2'h0;
  localparam logic [1:0] CH_DST = 2'h1;
  localparam logic [1:0] CH_CTL = 2'h2;
  localparam logic [7:0] A_EDGE = 8'h40;
  localparam logic [7:0] A_STAT = 8'h41;
  localparam logic [7:0] A_IEN = 8'h42;
  localparam logic [7:0] A_ICLR = 8'h43;
  localparam logic [7:0] A_STATE = 8'h44;
  localparam logic [15:0] SRC_WR_MASK = 16'h03ff;
  localparam logic [15:0] CH_WR_MASK = 16'h07ff;
  localparam logic [15:0] RST_VAL = 16'h0000;
  // ************
  // Fields
  // ************
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  localparam int EV_DONE = 0;
  localparam int EV_TRAP = 1;
  localparam int EV_EXT = 2;
  localparam int NEV = 3;
  // ************
  // Vectors and timing
  // ************
  localparam logic [6:0] VEC_LO_BASE = 7'h10;
  localparam logic [6:0] VEC_HI_BASE = 7'h30;
  localparam logic [6:0] VEC_LAST = 7'h44;
  localparam logic [4:0] SRC_HI_FIRST = 5'h10;
  localparam logic [4:0] SRC_LAST = 5'h1d;
  localparam int RESP_MIN_CLK = 5;
  localparam int RESP_MAX_CLK = 12;
  localparam logic [3:0] RESP_WAIT_LAST = 4'(RESP_MIN_CLK - 2);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_REQ = 2'b10
  } st_e;

  typedef struct packed {
    logic [5:0] rsvd;
    logic xfer;
    logic [2:0] chan;
    logic req;
    logic en;
    logic [3:0] level;
  } srcCtl_s;

  typedef struct packed {
    logic [4:0] rsvd;
    logic incDst;
    logic word;
    logic cont;
    logic [7:0] cnt;
  } chCtl_s;

  typedef struct packed {
    logic valid;
    logic [3:0] level;
    logic [6:0] vecNum;
    logic [8:0] vecAddr;
  } cpuReq_s;

  typedef struct packed {
    logic valid;
    logic word;
    logic [15:0] srcPtr;
    logic [15:0] dstPtr;
  } xferReq_s;
endpackage
`default_nettype wire

//--- prio_int_ctrl.sv
// Purpose: Priority interrupt controller with event transfer engine
// Assumes: One clock; peripheral requests are one-cycle pulses
// Notes: Level 0 never wins; ties go to the lowest source index
// Summary of operation
// - A request reaches the core between 5 and 12 clocks after its flag sets.
// - Each source is routed to a vectored interrupt or to a transfer channel.
// - A transfer costs the core one acknowledged cycle and no vector branch.
// - A transfer moves a byte or word and steps the source or destination pointer.
// - Each transfer counts the channel down by one, except in continuous mode.
// - When the count runs out the source falls back to its own vector.
// - Eight channels each hold their own pointers, count and mode.
// - Each source has a control register with request, enable and level.
// - The level field selects one of sixteen levels.
// - Only a source level strictly above the running level is passed on; a trap goes at the running level.
// - Each source has its own distinct vector.
// - Vector address is four times the vector number in segment zero.
// - Fast external inputs trigger on rising, falling or both edges.
// - A software trap number from the core is served as a vector.
// - Software setting an unused request flag makes a valid request.
`timescale 1ns/1ps
`default_nettype none
module prio_int_ctrl (
  // Clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [prio_int_pkg::ADDR_W-1:0] regAddr,
  input wire logic [prio_int_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [prio_int_pkg::DATA_W-1:0] regRdData,
  // Request sources
  input wire logic [prio_int_pkg::NSRC-1:0] periphReq,
  input wire logic [prio_int_pkg::NEXT-1:0] extIn,
  // CPU core
  input wire logic [3:0] cpuRunLevel,
  input wire logic intAck,
  input wire logic trapReq,
  input wire logic [6:0] trapNum,
  output var prio_int_pkg::cpuReq_s cpuReq,
  // Transfer engine
  output var prio_int_pkg::xferReq_s xferReq,
  input wire logic xferAck,
  // Interrupt
  output logic irq
);
  import prio_int_pkg::*;

  localparam int RESP_HI = 11;

  srcCtl_s srcCtl_ff [NSRC];
  chCtl_s chCtl_ff [NCH];
  logic [15:0] chSrc_ff [NCH];
  logic [15:0] chDst_ff [NCH];
  logic [15:0] edgeMode_ff;
  logic [NEV-1:0] status_ff;
  logic [NEV-1:0] ien_ff;
  logic [NEXT-1:0] extS1_ff;
  logic [NEXT-1:0] extS2_ff;
  logic [NEXT-1:0] extPrev_ff;
  logic [NEXT-1:0] extHit;
  logic [NSRC-1:0] hwSet;
  logic trapPend_ff;
  logic [6:0] trapNum_ff;
  st_e state_ff;
  logic [3:0] waitCnt_ff;
  logic [4:0] selSrc_ff;
  logic [2:0] selChan_ff;
  logic [3:0] selLvl_ff;
  logic selTrap_ff;
  logic selXfer_ff;
  logic winValid;
  logic [4:0] winIdx;
  logic [3:0] winLvl;
  logic [2:0] winChan;
  logic winXfer;
  logic ackInt;
  logic ackXfer;
  logic lastXfer;
  logic clrSrc;
  logic [6:0] vecNum;
  logic [DATA_W-1:0] rdMux;

  function automatic logic [6:0] vecOf(input logic [4:0] s);
    if (s < SRC_HI_FIRST) begin
      return VEC_LO_BASE + 7'(s);
    end else if (s < SRC_LAST) begin
      return VEC_HI_BASE + 7'(s - SRC_HI_FIRST);
    end
    return VEC_LAST;
  endfunction

  // ************
  // Fast external inputs
  // ************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      extS1_ff <= '0;
      extS2_ff <= '0;
      extPrev_ff <= '0;
    end else if (ce) begin
      extS1_ff <= extIn;
      extS2_ff <= extS1_ff;
      extPrev_ff <= extS2_ff;
    end
  end

  for (genvar j = 0; j < NEXT; j++) begin : g_ext
    // Mode bit 0 rising, bit 1 falling, both bits any edge
    assign extHit[j] =
      (edgeMode_ff[2*j+EDGE_RISE_BIT] & extS2_ff[j] & ~extPrev_ff[j]) |
      (edgeMode_ff[2*j+EDGE_FALL_BIT] & ~extS2_ff[j] & extPrev_ff[j]);
  end

  assign hwSet = periphReq | (NSRC'(extHit) << EXT_SRC_BASE);

  // ************
  // Arbitration
  // ************
  always_comb begin
    winValid = 1'b0;
    winIdx = '0;
    winLvl = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (srcCtl_ff[i].req && srcCtl_ff[i].en &&
          srcCtl_ff[i].level > cpuRunLevel &&
          (!winValid || srcCtl_ff[i].level > winLvl)) begin
        winValid = 1'b1;
        winIdx = 5'(i);
        winLvl = srcCtl_ff[i].level;
      end
    end
  end

  assign winChan = srcCtl_ff[winIdx].chan;
  // Exhausted count falls back to the vector
  assign winXfer = srcCtl_ff[winIdx].xfer &&
    (chCtl_ff[winChan].cont || chCtl_ff[winChan].cnt != 8'h00);

  assign ackInt = (state_ff == ST_REQ) && !selXfer_ff && intAck;
  assign ackXfer = (state_ff == ST_REQ) && selXfer_ff && xferAck;
  assign lastXfer = ackXfer && !chCtl_ff[selChan_ff].cont &&
    chCtl_ff[selChan_ff].cnt == 8'h01;
  // Last transfer keeps the flag so the vector follows
  assign clrSrc = (ackInt && !selTrap_ff) || (ackXfer && !lastXfer);
  assign vecNum = selTrap_ff ? trapNum_ff : vecOf(selSrc_ff);

  // ************
  // Software trap
  // ************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trapPend_ff <= 1'b0;
      trapNum_ff <= '0;
    end else if (ce) begin
      if (ackInt && selTrap_ff) begin
        trapPend_ff <= 1'b0;
      end
      if (trapReq && !trapPend_ff) begin
        trapPend_ff <= 1'b1;
        trapNum_ff <= trapNum;
      end
    end
  end

  // ************
  // Service sequencer
  // ************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      waitCnt_ff <= '0;
      selSrc_ff <= '0;
      selChan_ff <= '0;
      selLvl_ff <= '0;
      selTrap_ff <= 1'b0;
      selXfer_ff <= 1'b0;
      cpuReq <= '0;
      xferReq <= '0;
    end else if (ce) begin
      case (state_ff)
        ST_IDLE: begin
          if (trapPend_ff || winValid) begin
            state_ff <= ST_WAIT;
            waitCnt_ff <= '0;
            selTrap_ff <= trapPend_ff;
            selSrc_ff <= winIdx;
            selChan_ff <= winChan;
            selLvl_ff <= trapPend_ff ? cpuRunLevel : winLvl;
            selXfer_ff <= !trapPend_ff && winXfer;
          end
        end
        ST_WAIT: begin
          if (!selTrap_ff && !srcCtl_ff[selSrc_ff].req) begin
            state_ff <= ST_IDLE;
          end else if (waitCnt_ff == RESP_WAIT_LAST) begin
            state_ff <= ST_REQ;
            if (selXfer_ff) begin
              xferReq.valid <= 1'b1;
              xferReq.word <= chCtl_ff[selChan_ff].word;
              xferReq.srcPtr <= chSrc_ff[selChan_ff];
              xferReq.dstPtr <= chDst_ff[selChan_ff];
            end else begin
              cpuReq.valid <= 1'b1;
              cpuReq.level <= selLvl_ff;
              cpuReq.vecNum <= vecNum;
              cpuReq.vecAddr <= {vecNum, 2'b00};
            end
          end else begin
            waitCnt_ff <= waitCnt_ff + 4'h1;
          end
        end
        ST_REQ: begin
          if (ackInt || ackXfer) begin
            state_ff <= ST_IDLE;
            cpuReq.valid <= 1'b0;
            xferReq.valid <= 1'b0;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ************
  // Source control registers
  // ************
  for (genvar i = 0; i < NSRC; i++) begin : g_src
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        srcCtl_ff[i] <= srcCtl_s'(RST_VAL);
      end else if (ce) begin
        if (regWr && regAddr == A_SRC_BASE + 8'(i)) begin
          srcCtl_ff[i] <= srcCtl_s'(regWrData & SRC_WR_MASK);
        end
        if (clrSrc && selSrc_ff == 5'(i)) begin
          srcCtl_ff[i].req <= 1'b0;
        end
        if (hwSet[i]) begin
          srcCtl_ff[i].req <= 1'b1;
        end
      end
    end
  end

  // ************
  // Transfer channels
  // ************
  for (genvar k = 0; k < NCH; k++) begin : g_ch
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        chSrc_ff[k] <= RST_VAL;
        chDst_ff[k] <= RST_VAL;
        chCtl_ff[k] <= chCtl_s'(RST_VAL);
      end else if (ce) begin
        if (regWr && regAddr[7:2] == A_CH_BASE[7:2] + 6'(k)) begin
          case (regAddr[1:0])
            CH_SRC: chSrc_ff[k] <= regWrData;
            CH_DST: chDst_ff[k] <= regWrData;
            CH_CTL: chCtl_ff[k] <= chCtl_s'(regWrData & CH_WR_MASK);
            default: ;
          endcase
        end
        if (ackXfer && selChan_ff == 3'(k)) begin
          if (chCtl_ff[k].incDst) begin
            chDst_ff[k] <= chDst_ff[k] + (chCtl_ff[k].word ? 16'h0002 : 16'h0001);
          end else begin
            chSrc_ff[k] <= chSrc_ff[k] + (chCtl_ff[k].word ? 16'h0002 : 16'h0001);
          end
          if (!chCtl_ff[k].cont) begin
            chCtl_ff[k].cnt <= chCtl_ff[k].cnt - 8'h01;
          end
        end
      end
    end
  end

  // ************
  // Status, enable and interrupt
  // ************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_ff <= '0;
      ien_ff <= '0;
      edgeMode_ff <= RST_VAL;
      irq <= 1'b0;
    end else if (ce) begin
      // Set wins over a clear in the same cycle
      status_ff <= (status_ff & ~((regWr && regAddr == A_ICLR) ? regWrData[NEV-1:0] : '0)) |
        {|extHit, ackInt && selTrap_ff, lastXfer};
      if (regWr && regAddr == A_IEN) begin
        ien_ff <= regWrData[NEV-1:0];
      end
      if (regWr && regAddr == A_EDGE) begin
        edgeMode_ff <= regWrData;
      end
      irq <= |(status_ff & ien_ff);
    end
  end

  // ************
  // Register read
  // ************
  always_comb begin
    rdMux = '0;
    if (regAddr < A_SRC_END) begin
      rdMux = srcCtl_ff[regAddr[4:0]];
    end else if (regAddr[7:5] == A_CH_BASE[7:5]) begin
      case (regAddr[1:0])
        CH_SRC: rdMux = chSrc_ff[regAddr[4:2]];
        CH_DST: rdMux = chDst_ff[regAddr[4:2]];
        CH_CTL: rdMux = chCtl_ff[regAddr[4:2]];
        default: rdMux = '0;
      endcase
    end else begin
      case (regAddr)
        A_EDGE: rdMux = edgeMode_ff;
        A_STAT: rdMux = DATA_W'(status_ff);
        A_IEN: rdMux = DATA_W'(ien_ff);
        A_STATE: rdMux = {4'h0, state_ff, selTrap_ff, selXfer_ff, selChan_ff, selSrc_ff};
        default: rdMux = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdData <= '0;
    end else if (ce) begin
      regRdData <= regRd ? rdMux : '0;
    end
  end

  // ************
  // Assertions
  // ************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst || !ce);

  a_resp_min_wait: assert property ($rose(cpuReq.valid) |-> $past(state_ff == ST_WAIT, 4))
    else $error("request left the wait too early");
  a_resp_max_wait: assert property ((state_ff == ST_WAIT && waitCnt_ff == 4'h0) |->
    ##[1:RESP_HI] state_ff != ST_WAIT)
    else $error("request wait too long");
  a_xfer_one_cycle: assert property (ackXfer |=> !xferReq.valid && !cpuReq.valid)
    else $error("transfer held more than one cycle");
  a_xfer_ptr_step: assert property (ackXfer |=>
    chSrc_ff[$past(selChan_ff)] != $past(chSrc_ff[selChan_ff]) ||
    chDst_ff[$past(selChan_ff)] != $past(chDst_ff[selChan_ff]))
    else $error("no pointer stepped");
  a_count_down: assert property ((ackXfer && !chCtl_ff[selChan_ff].cont) |=>
    chCtl_ff[$past(selChan_ff)].cnt == $past(chCtl_ff[selChan_ff].cnt) - 8'h01)
    else $error("count not decremented");
  a_last_vectors: assert property (lastXfer |=>
    srcCtl_ff[$past(selSrc_ff)].req && status_ff[EV_DONE])
    else $error("exhausted channel lost its request");
  a_level_above: assert property ((state_ff == ST_IDLE && winValid && !trapPend_ff) |=>
    selLvl_ff > $past(cpuRunLevel))
    else $error("level not above running level");
  a_vector_addr: assert property (cpuReq.valid |-> cpuReq.vecAddr == {cpuReq.vecNum, 2'b00})
    else $error("vector address mismatch");
  a_ack_clears: assert property ((ackInt && !selTrap_ff && !hwSet[selSrc_ff]) |=>
    !srcCtl_ff[$past(selSrc_ff)].req)
    else $error("accepted flag still set");
  a_edge_sets: assert property (extHit[0] |=> srcCtl_ff[EXT_SRC_BASE].req)
    else $error("edge did not set flag");
  a_trap_vector: assert property (($rose(cpuReq.valid) && selTrap_ff) |->
    cpuReq.vecNum == trapNum_ff)
    else $error("trap vector mismatch");
endmodule
`default_nettype wire

//--- cpu_core_model.sv
// Purpose: Behavioural CPU core that acknowledges service requests
// Assumes: One service at a time, acknowledge is a one-cycle pulse
// Notes: ackDelay picks a prompt (0) or slow answer
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Service requests
  input wire prio_int_pkg::cpuReq_s cpuReq,
  input wire prio_int_pkg::xferReq_s xferReq,
  input wire logic [3:0] ackDelay,
  // Acknowledges
  output logic intAck,
  output logic xferAck
);
  import prio_int_pkg::*;
  logic [3:0] waitCnt_ff;
  logic intAck_ff;
  logic xferAck_ff;
  assign intAck = intAck_ff;
  assign xferAck = xferAck_ff;
  // Ack a standing request after ackDelay cycles, then rest one cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      waitCnt_ff <= 4'h0;
      intAck_ff <= 1'h0;
      xferAck_ff <= 1'h0;
    end else if (intAck_ff || xferAck_ff) begin
      waitCnt_ff <= 4'h0;
      intAck_ff <= 1'h0;
      xferAck_ff <= 1'h0;
    end else if (cpuReq.valid || xferReq.valid) begin
      if (waitCnt_ff == ackDelay) begin
        intAck_ff <= cpuReq.valid;
        xferAck_ff <= xferReq.valid;
      end else begin
        waitCnt_ff <= waitCnt_ff + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- priority_interrupt_with_pec_tb.sv
// Purpose: Self-checking bench of the priority interrupt controller
// Assumes: Core acknowledges come from cpu_core_model
// Notes: Clock enable dropped once to check that state freezes
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_with_pec_tb;
  import prio_int_pkg::*;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic [ADDR_W-1:0] regAddr = 8'h00;
  logic [DATA_W-1:0] regWrData = 16'h0000;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic [DATA_W-1:0] regRdData;
  logic [NSRC-1:0] periphReq = '0;
  logic [NEXT-1:0] extIn = 8'h00;
  logic [3:0] cpuRunLevel = 4'h0;
  logic trapReq = 1'h0;
  logic [6:0] trapNum = 7'h00;
  logic [3:0] ackDelay = 4'h0;
  logic intAck;
  logic xferAck;
  logic irq;
  cpuReq_s cpuReq;
  xferReq_s xferReq;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int lat;

  always #25 clk_sys = ~clk_sys;

  prio_int_ctrl dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .periphReq(periphReq), .extIn(extIn),
    .cpuRunLevel(cpuRunLevel), .intAck(intAck), .trapReq(trapReq), .trapNum(trapNum), .cpuReq(cpuReq),
    .xferReq(xferReq), .xferAck(xferAck), .irq(irq));
  cpu_core_model core (.clk_sys(clk_sys), .rst(rst), .cpuReq(cpuReq), .xferReq(xferReq),
    .ackDelay(ackDelay), .intAck(intAck), .xferAck(xferAck));

  // ************
  // Shared tasks
  // ************
  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'h0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1 chk(what, regRdData, exp);
  endtask
  task automatic pulse(input logic [4:0] s);
    @(posedge clk_sys);
    periphReq[s] <= 1'h1;
    @(posedge clk_sys);
    periphReq[s] <= 1'h0;
  endtask
  task automatic waitSvc(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (cpuReq.valid !== 1'h1 && xferReq.valid !== 1'h1 && n < 30);
  endtask
  task automatic idleWait();
    int n = 0;
    while ((cpuReq.valid !== 1'h0 || xferReq.valid !== 1'h0) && n < 30) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  task automatic expSvc(input logic exp, input logic [6:0] vec);
    waitSvc(lat);
    chk("served", cpuReq.valid | xferReq.valid, exp);
    if (exp) chk("vecNum", cpuReq.vecNum, vec);
    idleWait();
  endtask
  task automatic irqChk(input logic exp);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq", irq, exp);
  endtask

  // ************
  // Scenarios
  // ************
  task automatic t_regs();
    rdChk(8'h05, 16'h0000, "src reset");
    rdChk(A_STAT, 16'h0000, "stat reset");
    rdChk(A_STATE, 16'h0000, "state idle");
    wr(8'h05, 16'hffdf);
    rdChk(8'h05, 16'h03df, "src fields");
    wr(8'h05, 16'h0000);
    wr(8'h50, 16'h1234);
    rdChk(8'h50, 16'h0000, "unmapped");
    for (int k = 0; k < NCH; k++) wr(8'(A_CH_BASE + 4*k), 16'(16'h0100 * k + 16'h0011));
    for (int k = 0; k < NCH; k++) rdChk(8'(A_CH_BASE + 4*k), 16'(16'h0100 * k + 16'h0011), "chan");
  endtask
  task automatic t_vec();
    logic [4:0] src [6] = '{5'h00, 5'h03, 5'h0f, 5'h10, 5'h1c, 5'h1d};
    logic [6:0] num [6] = '{7'h10, 7'h13, 7'h1f, 7'h30, 7'h3c, 7'h44};
    for (int k = 0; k < 6; k++) begin
      ackDelay <= 4'(k);
      wr({3'h0, src[k]}, 16'h0015);
      pulse(src[k]);
      waitSvc(lat);
      chk("latency", lat >= 5 && lat <= 12, 1'h1);
      chk("vecNum", cpuReq.vecNum, num[k]);
      chk("vecAddr", cpuReq.vecAddr, {num[k], 2'h0});
      chk("level", cpuReq.level, 4'h5);
      idleWait();
      rdChk({3'h0, src[k]}, 16'h0015, "flag clr");
      wr({3'h0, src[k]}, 16'h0000);
    end
  endtask
  task automatic t_prio();
    @(posedge clk_sys);
    cpuRunLevel <= 4'h9;
    wr(8'h01, 16'h0030);
    wr(8'h14, 16'h0033);
    wr(8'h05, 16'h0039);
    expSvc(1'h0, 7'h00);
    @(posedge clk_sys);
    cpuRunLevel <= 4'h8;
    expSvc(1'h1, 7'h15);
    expSvc(1'h0, 7'h00);
    @(posedge clk_sys);
    cpuRunLevel <= 4'h0;
    expSvc(1'h1, 7'h34);
    expSvc(1'h0, 7'h00);
    wr(8'h01, 16'h0000);
  endtask
  task automatic t_xfer();
    ackDelay <= 4'h0;
    wr(8'h28, 16'h1000);
    wr(8'h29, 16'h2000);
    wr(8'h2a, 16'h0202);
    wr(A_IEN, 16'h0001);
    wr(8'h07, 16'h0296);
    for (int i = 0; i < 2; i++) begin
      pulse(5'h07);
      waitSvc(lat);
      chk("xfer", xferReq.valid, 1'h1);
      chk("no vector", cpuReq.valid, 1'h0);
      chk("word", xferReq.word, 1'h1);
      chk("srcPtr", xferReq.srcPtr, 16'(16'h1000 + 2*i));
      chk("dstPtr", xferReq.dstPtr, 16'h2000);
      @(posedge clk_sys);
      #1 chk("ack", xferAck, 1'h1);
      @(posedge clk_sys);
      #1 chk("one cycle", xferReq.valid, 1'h0);
      if (i == 1) expSvc(1'h1, 7'h17);
      rdChk(8'h2a, 16'(16'h0201 - i), "count");
      rdChk(8'h28, 16'(16'h1002 + 2*i), "src step");
    end
    rdChk(A_STAT, 16'h0001, "stat done");
    irqChk(1'h1);
    wr(A_IEN, 16'h0000);
    irqChk(1'h0);
    wr(A_IEN, 16'h0001);
    irqChk(1'h1);
    wr(A_ICLR, 16'h0001);
    irqChk(1'h0);
    rdChk(A_STAT, 16'h0000, "stat clr");
    wr(8'h07, 16'h0000);
    wr(8'h2c, 16'h3000);
    wr(8'h2d, 16'h4000);
    wr(8'h2e, 16'h0505);
    wr(8'h14, 16'h02d6);
    pulse(5'h14);
    waitSvc(lat);
    chk("byte", xferReq.word, 1'h0);
    chk("dstPtr", xferReq.dstPtr, 16'h4000);
    idleWait();
    rdChk(8'h2e, 16'h0505, "count cont");
    rdChk(8'h2d, 16'h4001, "dst step");
    rdChk(8'h2c, 16'h3000, "src kept");
    wr(8'h14, 16'h0000);
  endtask
  task automatic t_ext();
    wr(A_EDGE, 16'h0039);
    for (int j = 0; j < 3; j++) begin
      wr(8'(EXT_SRC_BASE + j), 16'h0015);
      @(posedge clk_sys);
      extIn[j] <= 1'h1;
      expSvc(j != 1, 7'(7'h18 + j));
      @(posedge clk_sys);
      extIn[j] <= 1'h0;
      expSvc(j != 0, 7'(7'h18 + j));
    end
    rdChk(A_STAT, 16'h0004, "stat ext");
    wr(A_ICLR, 16'h0007);
  endtask
  task automatic t_ce();
    @(posedge clk_sys);
    ce <= 1'h0;
    wr(8'h03, 16'h0015);
    @(posedge clk_sys);
    ce <= 1'h1;
    rdChk(8'h03, 16'h0000, "ce frozen");
    @(posedge clk_sys);
    #1 chk("rd idle", regRdData, 16'h0000);
  endtask
  task automatic t_trap();
    @(posedge clk_sys);
    trapReq <= 1'h1;
    trapNum <= 7'h2a;
    @(posedge clk_sys);
    trapReq <= 1'h0;
    waitSvc(lat);
    chk("trap latency", lat >= 5 && lat <= 12, 1'h1);
    chk("trap vecNum", cpuReq.vecNum, 7'h2a);
    chk("trap vecAddr", cpuReq.vecAddr, 9'h0a8);
    idleWait();
    rdChk(A_STAT, 16'h0002, "stat trap");
    wr(A_ICLR, 16'h0002);
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    t_regs();
    t_ce();
    t_vec();
    t_prio();
    t_xfer();
    t_ext();
    t_trap();
    test_done();
  end
endmodule
`default_nettype wire
